/* dv/sdd_core_model.sv */
module sdd_core_model (
    input wire logic clk,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    output logic [7:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic timedOut
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        timedOut = 1'b0;
    end
    // The request stays put until waitrequest is seen low at an edge.
    // A spare edge first keeps the last release apart from a new request.
    task automatic xfer(input logic [7:0] a, input logic w,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        avs_writedata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 100);
        r = avs_readdata;
        timedOut = (n >= 100);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule

/* dv/testbench.sv */
`include "sdd_defines.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] ZERO = 32'h0000_0000;
    logic clk;
    logic rst_n;
    logic ce;
    logic [7:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic timedOut;
    logic faceFetch;
    logic faceBorder;
    logic [31:0] q;
    int nFail;
    int comparisons;
    ////////////////////////////////////////////////////////////
    sdd_surface_decode i_sdd_surface_decode (.clk, .rst_n, .ce,
        .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest,
        .faceFetchOut(faceFetch), .faceBorderOut(faceBorder));
    sdd_core_model i_sdd_core_model (.clk, .avs_readdata,
        .avs_waitrequest, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .timedOut);
    ////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(string s, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            nFail++;
            $display("MISMATCH %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic bus(logic [7:0] a, logic w, logic [31:0] d);
        i_sdd_core_model.xfer(a, w, d, q);
        if (timedOut) begin
            nFail++;
            end_sim();
        end
    endtask
    task automatic desc(logic [31:0] d0, d1, d2, d3);
        bus(`SDD_OFF_DESC0, 1'b1, d0);
        bus(`SDD_OFF_DESC1, 1'b1, d1);
        bus(`SDD_OFF_DESC2, 1'b1, d2);
        bus(`SDD_OFF_DESC3, 1'b1, d3);
    endtask
    // Results land one edge after the query write is stored; the task waits three edges.
    task automatic ask(logic [31:0] v, logic [7:0] a);
        bus(`SDD_OFF_QUERY, 1'b1, v);
        repeat (3) @(posedge clk);
        bus(a, 1'b0, ZERO);
    endtask
    task automatic rc(logic [1:0] m, logic [2:0] f, logic [15:0] r,
        logic [16:0] e);
        desc({3'h1, 16'h0000, f[2:1], 3'h0, m, 6'h00}, ZERO,
            {13'h0009, 19'h0_0000}, ZERO);
        ask({12'h000, f[0], 3'h0, r}, `SDD_OFF_ROW);
        chk("row", {15'h0000, e}, q);
    endtask
    task automatic testRows();
        rc(2'h0, 3'h1, 16'hFFFD, 17'h1_0000);
        rc(2'h0, 3'h1, 16'h000C, 17'h1_0009);
        rc(2'h0, 3'h7, 16'hFFFF, 17'h1_0001);
        rc(2'h0, 3'h7, 16'h0004, 17'h0_0009);
        rc(2'h1, 3'h7, 16'hFFFF, 17'h1_0001);
        rc(2'h2, 3'h7, 16'hFFFF, 17'h1_0000);
        rc(2'h2, 3'h7, 16'h000C, 17'h1_0013);
        rc(2'h2, 3'h6, 16'hFFFF, 17'h1_0001);
        rc(2'h3, 3'h7, 16'hFFFF, 17'h1_0001);
        rc(2'h3, 3'h1, 16'hFFFD, 17'h1_0001);
        rc(2'h3, 3'h1, 16'hFFFC, 17'h1_0000);
        rc(2'h3, 3'h1, 16'h000C, 17'h1_0008);
        $display("rows done");
    endtask
    task automatic testFaces();
        logic m;
        desc({3'h3, 23'h00_0000, 6'h2A}, ZERO, {13'h000F, 13'h000F, 6'h00},
            ZERO);
        for (int f = 0; f < 7; f++) begin
            m = (f < 6) ? 1'(6'h2A >> (5 - f)) : 1'b0;
            ask({13'h0000, f[2:0], 16'h0000}, `SDD_OFF_FACE);
            chk("face", {ZERO[29:0], ~m, m}, q);
            chk("pins", {ZERO[29:0], ~m, m}, {ZERO[29:0], faceBorder,
                faceFetch});
        end
        // A low clock enable must hold the last query's results.
        bus(`SDD_OFF_QUERY, 1'b1, ZERO);
        ce <= 1'b0;
        repeat (3) @(posedge clk);
        chk("frozen", 32'h0000_0002, {ZERO[29:0], faceBorder, faceFetch});
        ce <= 1'b1;
        ask(ZERO, `SDD_OFF_FACE);
        chk("face", 32'h0000_0001, q);
        desc({3'h1, 29'h0000_0000}, ZERO, ZERO, ZERO);
        ask(32'h0005_0000, `SDD_OFF_FACE);
        chk("face", 32'h0000_0001, q);
        $display("faces done");
    endtask
    task automatic testOther();
        desc(32'h8000_0000, ZERO, {13'h1ABC, 6'h00, 7'h55, 6'h00},
            {4'h0, 7'h2A, 21'h00_0000});
        ask(ZERO, `SDD_OFF_BUFCNT);
        chk("count", {5'h00, 7'h2A, 13'h1ABC, 7'h55}, q);
        bus(`SDD_OFF_OFFSET, 1'b1, 32'h0000_0200);
        desc(32'h3000_0000, 32'h1234_5000, ZERO, ZERO);
        ask(ZERO, `SDD_OFF_ADDR);
        chk("tiled", 32'h1234_5240, q);
        desc(32'h2000_0000, 32'h1234_5000, ZERO, ZERO);
        ask(ZERO, `SDD_OFF_ADDR);
        chk("linear", 32'h1234_5200, q);
        desc(32'h2000_1000, ZERO, {13'h0063, 13'h027F, 6'h00}, ZERO);
        ask(32'h0008_0000, `SDD_OFF_SIZE);
        chk("size", {4'h3, 14'h0064, 14'h0280}, q);
        desc(32'h4000_0080, ZERO, {13'h0800, 19'h0_0000}, ZERO);
        ask(ZERO, `SDD_OFF_STATUS);
        chk("range", 32'h0000_001A, q);
        $display("other done");
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        rst_n = 1'b0;
        ce = 1'b1;
        nFail = 0;
        comparisons = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(`SDD_OFF_STATUS, 1'b0, ZERO);
        chk("status", ZERO, q);
        bus(8'h30, 1'b0, ZERO);
        chk("unmapped", ZERO, q);
        testRows();
        testFaces();
        testOther();
        end_sim();
    end
endmodule

/* rtl/sdd_defines.svh */
`ifndef SDD_DEFINES_SVH
`define SDD_DEFINES_SVH

`define SDD_OFF_DESC0 8'h00
`define SDD_OFF_DESC1 8'h04
`define SDD_OFF_DESC2 8'h08
`define SDD_OFF_DESC3 8'h0C
`define SDD_OFF_QUERY 8'h10
`define SDD_OFF_ROW 8'h14
`define SDD_OFF_FACE 8'h18
`define SDD_OFF_SIZE 8'h1C
`define SDD_OFF_BUFCNT 8'h20
`define SDD_OFF_ADDR 8'h24
`define SDD_OFF_STATUS 8'h28
`define SDD_OFF_OFFSET 8'h2C

`define SDD_TYPE_HI 31
`define SDD_TYPE_LO 29
`define SDD_TILED_BIT 28
`define SDD_STRIDE_BIT 12
`define SDD_STROFF_BIT 11
`define SDD_MODE_HI 7
`define SDD_MODE_LO 6
`define SDD_FACE_HI 5
`define SDD_FACE_LO 0
`define SDD_HEIGHT_HI 31
`define SDD_HEIGHT_LO 19
`define SDD_WIDTH_HI 18
`define SDD_WIDTH_LO 6
`define SDD_DEPTH_HI 31
`define SDD_DEPTH_LO 21
`define SDD_QROW_HI 15
`define SDD_QROW_LO 0
`define SDD_QFACE_HI 18
`define SDD_QFACE_LO 16
`define SDD_QMEDIA_BIT 19
`define SDD_SWZ_DST 6
`define SDD_SWZ_SRC 9

`define SDD_RST_WORD 32'h0000_0000
`define SDD_MAX_VOL 13'h07FF
`define SDD_LAST_FACE 3'h5

`endif

/* rtl/sdd_dim_decode.sv */
`include "sdd_defines.svh"

module sdd_dim_decode (
    input wire sdd_pkg::sdd_stype_t sType,
    input wire logic [12:0] widthField,
    input wire logic [12:0] heightField,
    input wire logic [10:0] depthField,
    input wire logic [5:0] faceMask,
    input wire logic [2:0] faceIdx,
    output logic [13:0] widthCount,
    output logic [13:0] heightCount,
    output logic [26:0] bufCountM1,
    output logic faceFetch,
    output logic rangeErr
);

    logic faceOn;
    logic isCube;

    function automatic logic [13:0] plusOne(input logic [12:0] f);
        plusOne = {1'b0, f} + 14'h0001;
    endfunction

    assign widthCount = plusOne(widthField); // RQ16
    assign heightCount = plusOne(heightField); // RQ15
    // Upper bits of the slices are taken as cleared by software.
    assign bufCountM1 = {depthField[6:0], heightField,
                         widthField[6:0]}; // RQ17 RQ23
    assign faceOn = (faceIdx <= `SDD_LAST_FACE)
                    && faceMask[`SDD_LAST_FACE - faceIdx]; // RQ7
    assign isCube = sType == sdd_pkg::cube_surface_type;
    assign faceFetch = !isCube || faceOn; // RQ6 RQ9
    assign rangeErr = (sType == sdd_pkg::volume_surface_type
                       && (widthField > `SDD_MAX_VOL
                           || heightField > `SDD_MAX_VOL))
                      || (sType == sdd_pkg::one_dim_surface_type
                          && heightField != 13'h0000); // RQ15 RQ16

endmodule

/* rtl/sdd_pkg.sv */
package sdd_pkg;

    typedef enum logic [1:0] {
        boundary_normal = 2'h0,
        boundary_reserved = 2'h1,
        boundary_nearest_frame_row = 2'h2,
        boundary_parity_preserving = 2'h3
    } sdd_bmode_t;

    typedef enum logic [2:0] {
        one_dim_surface_type = 3'h0,
        two_dim_surface_type = 3'h1,
        volume_surface_type = 3'h2,
        cube_surface_type = 3'h3,
        buffer_surface_type = 3'h4
    } sdd_stype_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } sdd_bus_t;

    typedef enum logic [1:0] {
        QRY_IDLE = 2'b00,
        QRY_CALC = 2'b01,
        QRY_DONE = 2'b11
    } sdd_qry_t;

endpackage

/* rtl/sdd_row_clamp.sv */
module sdd_row_clamp (
    input wire logic signed [15:0] reqRow,
    input wire logic [12:0] heightM1,
    input wire logic fieldMode,
    input wire logic fieldOdd,
    input wire sdd_pkg::sdd_bmode_t mode,
    output logic [15:0] physRow,
    output logic outOfBounds
);

    logic signed [17:0] r;
    logic signed [17:0] h;
    logic signed [17:0] frameHi;
    logic signed [17:0] lr;
    logic signed [17:0] res;

    function automatic logic signed [17:0] clampTo(
        input logic signed [17:0] v,
        input logic signed [17:0] hi
    );
        clampTo = (v < 18'sh0_0000) ? 18'sh0_0000 : ((v > hi) ? hi : v);
    endfunction

    assign r = {{2{reqRow[15]}}, reqRow};
    assign h = {5'h00, heightM1};
    assign frameHi = {4'h0, heightM1, 1'b1};
    assign lr = clampTo(r, h);
    assign outOfBounds = (r < 18'sh0_0000) || (r > h);

    always_comb begin
        // Field rows are interleaved: physical row is twice the logical one plus the odd-field bit.
        res = fieldMode ? {lr[16:0], fieldOdd} : lr; // RQ1 RQ4
        if (mode == sdd_pkg::boundary_nearest_frame_row && fieldMode) begin
            res = clampTo({r[16:0], fieldOdd}, frameHi); // RQ2
        end
        if (mode == sdd_pkg::boundary_parity_preserving && !fieldMode
            && h != 18'sh0_0000) begin
            if (r < 18'sh0_0000) begin
                res = {17'h0_0000, r[0]}; // RQ3
            end else if (r > h) begin
                res = (r[0] == h[0]) ? h : h - 18'sh0_0001; // RQ3
            end
        end
    end

    assign physRow = res[15:0];

endmodule

/* rtl/sdd_surface_decode.sv */
`include "sdd_defines.svh"

// Overview of operation
// (RQ1) Mode 0: out-of-bounds rows clamp within frame or own field.
// (RQ2) Mode 2: clamp to nearest row of whole frame, also in field mode.
// (RQ3) Mode 3: field clamps in field; frame keeps row parity.
// (RQ4) Line-skip 0 is frame mode; 1 is field mode, even or odd rows.
// (RQ5) Boundary mode only for 2D non-array media reads; else zero.
// (RQ6) Six-bit face mask: enabled faces fetch, disabled use border colour.
// (RQ7) Mask bits top down: -X, +X, -Y, +Y, -Z, +Z.
// (RQ8) Software still allocates storage for disabled cube faces.
// (RQ9) Face mask is ignored unless the surface is a cube.
// (RQ10) Second word holds the 32-bit byte base address.
// (RQ11) Tiled surface base addresses are 4KB aligned by software.
// (RQ12) Tiling touches only the offset, never the base address.
// (RQ13) Linear depth buffer bases are 64-byte aligned by software.
// (RQ14) Linear render target bases align to element or two elements.
// (RQ15) Third word 31:19 is height minus one, range by type.
// (RQ16) Third word 18:6 is width minus one, range by type.
// (RQ17) Buffer count minus one: width gives 6:0, height 19:7.
// (RQ18) Software right-justifies count slices and zeroes upper bits.
// (RQ19) With line-skip set, height means one field's height.
// (RQ20) Media block accesses count width in doublewords.
// (RQ21) Cube width equals height, set by software.
// (RQ22) YUV render target width is a multiple of two.
// (RQ23) Depth field gives count bits 26:20, completing 27 bits.
// (RQ24) Reserved boundary mode 1 behaves as mode 0.
////////////////////////////////////////////////////////////////////////
module sdd_surface_decode (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic faceFetchOut,
    output logic faceBorderOut
);

    sdd_pkg::sdd_bus_t bus_q;
    sdd_pkg::sdd_qry_t qry_q;
    logic [31:0] desc0_q;
    logic [31:0] desc1_q;
    logic [31:0] desc2_q;
    logic [31:0] desc3_q;
    logic [31:0] query_q;
    logic [31:0] offset_q;
    logic [16:0] rowRes_q;
    logic [31:0] size_q;
    logic [26:0] bufCnt_q;
    logic [31:0] addr_q;
    logic rangeErr_q;
    logic [31:0] rdata_d;
    logic writeHit;
    logic readTake;
    logic startQ;
    logic calcNow;
    sdd_pkg::sdd_stype_t sType;
    sdd_pkg::sdd_bmode_t modeRaw;
    sdd_pkg::sdd_bmode_t modeEff;
    logic [12:0] hField;
    logic [12:0] wField;
    logic [10:0] dField;
    logic [5:0] faceMask;
    logic [2:0] faceIdx;
    logic signed [15:0] reqRow;
    logic fieldMode;
    logic fieldOdd;
    logic media;
    logic tiled;
    logic modeApplies;
    logic progErr;
    logic [15:0] physRow;
    logic rowOob;
    logic [13:0] widthCount;
    logic [13:0] heightCount;
    logic [26:0] bufCountM1;
    logic faceFetch;
    logic rangeErr;

    ////////////////////////////////////////////////////////////////////
    // Helpers.

    function automatic logic [31:0] mergeBe(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [3:0] be
    );
        for (int i = 0; i < 4; i++) begin
            mergeBe[i*8 +: 8] = be[i] ? data[i*8 +: 8] : old[i*8 +: 8];
        end
    endfunction

    // Bank swizzle applied to the offset only, so the base stays intact.
    function automatic logic [31:0] tileOffset(
        input logic [31:0] off,
        input logic isTiled
    );
        tileOffset = off;
        if (isTiled) begin
            tileOffset[`SDD_SWZ_DST] = off[`SDD_SWZ_DST] ^ off[`SDD_SWZ_SRC];
        end
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Descriptor fields.

    assign sType = sdd_pkg::sdd_stype_t'(desc0_q[`SDD_TYPE_HI:`SDD_TYPE_LO]);
    assign modeRaw =
        sdd_pkg::sdd_bmode_t'(desc0_q[`SDD_MODE_HI:`SDD_MODE_LO]);
    assign faceMask = desc0_q[`SDD_FACE_HI:`SDD_FACE_LO];
    assign fieldMode = desc0_q[`SDD_STRIDE_BIT]; // RQ4
    assign fieldOdd = fieldMode && desc0_q[`SDD_STROFF_BIT]; // RQ4
    assign tiled = desc0_q[`SDD_TILED_BIT];
    assign hField = desc2_q[`SDD_HEIGHT_HI:`SDD_HEIGHT_LO]; // RQ15
    assign wField = desc2_q[`SDD_WIDTH_HI:`SDD_WIDTH_LO]; // RQ16
    assign dField = desc3_q[`SDD_DEPTH_HI:`SDD_DEPTH_LO];
    assign reqRow = $signed(query_q[`SDD_QROW_HI:`SDD_QROW_LO]);
    assign faceIdx = query_q[`SDD_QFACE_HI:`SDD_QFACE_LO];
    assign media = query_q[`SDD_QMEDIA_BIT];

    assign modeApplies = sType == sdd_pkg::two_dim_surface_type
                         && dField == 11'h000 && media; // RQ5
    assign progErr = modeRaw != sdd_pkg::boundary_normal
                     && !(sType == sdd_pkg::two_dim_surface_type
                          && dField == 11'h000); // RQ5

    always_comb begin
        modeEff = modeRaw;
        if (!modeApplies || modeRaw == sdd_pkg::boundary_reserved) begin
            modeEff = sdd_pkg::boundary_normal; // RQ5 RQ24
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Decoders.

    sdd_row_clamp u_row (
        .reqRow(reqRow),
        .heightM1(hField),
        .fieldMode(fieldMode),
        .fieldOdd(fieldOdd),
        .mode(modeEff),
        .physRow(physRow),
        .outOfBounds(rowOob)
    );

    sdd_dim_decode u_dim (
        .sType(sType),
        .widthField(wField),
        .heightField(hField),
        .depthField(dField),
        .faceMask(faceMask),
        .faceIdx(faceIdx),
        .widthCount(widthCount),
        .heightCount(heightCount),
        .bufCountM1(bufCountM1),
        .faceFetch(faceFetch),
        .rangeErr(rangeErr)
    );

    ////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, then a single acknowledge cycle.

    assign writeHit = bus_q == sdd_pkg::BUS_ACK && avs_write;
    assign readTake = bus_q == sdd_pkg::BUS_IDLE && avs_read;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            bus_q <= sdd_pkg::BUS_IDLE;
            avs_waitrequest <= 1'b1;
        end else if (ce) begin
            unique case (bus_q)
                sdd_pkg::BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_q <= sdd_pkg::BUS_ACK;
                        avs_waitrequest <= 1'b0;
                    end
                end
                sdd_pkg::BUS_ACK: begin
                    bus_q <= sdd_pkg::BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    always_comb begin
        unique case (avs_address)
            `SDD_OFF_DESC0: rdata_d = desc0_q;
            `SDD_OFF_DESC1: rdata_d = desc1_q; // RQ10
            `SDD_OFF_DESC2: rdata_d = desc2_q;
            `SDD_OFF_DESC3: rdata_d = desc3_q;
            `SDD_OFF_QUERY: rdata_d = query_q;
            `SDD_OFF_OFFSET: rdata_d = offset_q;
            `SDD_OFF_ROW: rdata_d = {15'h0000, rowRes_q};
            `SDD_OFF_FACE: rdata_d = {30'h0000_0000, faceBorderOut,
                                      faceFetchOut};
            `SDD_OFF_SIZE: rdata_d = size_q;
            `SDD_OFF_BUFCNT: rdata_d = {5'h00, bufCnt_q};
            `SDD_OFF_ADDR: rdata_d = addr_q;
            `SDD_OFF_STATUS: rdata_d = {27'h000_0000, rangeErr_q, progErr,
                                        modeRaw == sdd_pkg::boundary_reserved,
                                        qry_q == sdd_pkg::QRY_DONE,
                                        qry_q == sdd_pkg::QRY_CALC};
            default: rdata_d = `SDD_RST_WORD;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_readdata <= `SDD_RST_WORD;
        end else if (ce && readTake) begin
            avs_readdata <= rdata_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Descriptor and query registers.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            desc0_q <= `SDD_RST_WORD;
            desc1_q <= `SDD_RST_WORD;
            desc2_q <= `SDD_RST_WORD;
            desc3_q <= `SDD_RST_WORD;
            offset_q <= `SDD_RST_WORD;
        end else if (ce && writeHit) begin
            unique case (avs_address)
                `SDD_OFF_DESC0: begin
                    desc0_q <= mergeBe(desc0_q, avs_writedata, avs_byteenable);
                end
                `SDD_OFF_DESC1: begin
                    desc1_q <= mergeBe(desc1_q, avs_writedata, avs_byteenable);
                end
                `SDD_OFF_DESC2: begin
                    desc2_q <= mergeBe(desc2_q, avs_writedata, avs_byteenable);
                end
                `SDD_OFF_DESC3: begin
                    desc3_q <= mergeBe(desc3_q, avs_writedata, avs_byteenable);
                end
                `SDD_OFF_OFFSET: begin
                    offset_q <= mergeBe(offset_q, avs_writedata,
                                        avs_byteenable);
                end
                default: ;
            endcase
        end
    end

    assign startQ = writeHit && avs_address == `SDD_OFF_QUERY;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            query_q <= `SDD_RST_WORD;
        end else if (ce && startQ) begin
            query_q <= mergeBe(query_q, avs_writedata, avs_byteenable);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Query sequencer: results settle one cycle after the query lands.

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            qry_q <= sdd_pkg::QRY_IDLE;
        end else if (ce) begin
            unique case (qry_q)
                sdd_pkg::QRY_IDLE: begin
                    if (startQ) qry_q <= sdd_pkg::QRY_CALC;
                end
                sdd_pkg::QRY_CALC: qry_q <= sdd_pkg::QRY_DONE;
                sdd_pkg::QRY_DONE: begin
                    if (startQ) qry_q <= sdd_pkg::QRY_CALC;
                end
                default: qry_q <= sdd_pkg::QRY_IDLE;
            endcase
        end
    end

    assign calcNow = ce && qry_q == sdd_pkg::QRY_CALC;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rowRes_q <= 17'h0_0000;
        end else if (calcNow) begin
            rowRes_q <= {rowOob, physRow}; // RQ1 RQ2 RQ3
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            faceFetchOut <= 1'b0;
            faceBorderOut <= 1'b0;
        end else if (calcNow) begin
            faceFetchOut <= faceFetch; // RQ6 RQ9
            faceBorderOut <= !faceFetch; // RQ6
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            size_q <= `SDD_RST_WORD;
            bufCnt_q <= 27'h000_0000;
            rangeErr_q <= 1'b0;
        end else if (calcNow) begin
            // Width unit flag and field-height flag ride above the counts.
            size_q <= {2'b00, media, fieldMode, heightCount,
                       widthCount}; // RQ15 RQ16 RQ19 RQ20
            bufCnt_q <= bufCountM1; // RQ17 RQ23
            rangeErr_q <= rangeErr;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_q <= `SDD_RST_WORD;
        end else if (calcNow) begin
            addr_q <= desc1_q + tileOffset(offset_q, tiled); // RQ10 RQ12
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_NORMAL_CLAMP: assert property ( // RQ1
        calcNow && modeEff == sdd_pkg::boundary_normal && !fieldMode
        && reqRow > $signed({3'h0, hField}) |=> rowRes_q[15:0] ==
        {3'h0, $past(hField)} && rowRes_q[16]
    ) else $error("Mode 0 frame row not clamped to last row.");
    AST_FIELD_KEPT: assert property ( // RQ4
        calcNow && modeEff == sdd_pkg::boundary_normal && fieldMode
        |=> rowRes_q[0] == $past(fieldOdd)
    ) else $error("Field mode returned a row of the other field.");
    AST_FRAME_NEAREST: assert property ( // RQ2
        calcNow && modeEff == sdd_pkg::boundary_nearest_frame_row
        && fieldMode && reqRow < 16'sh0000 |=> rowRes_q[15:0] == 16'h0000
    ) else $error("Mode 2 did not return frame row zero.");
    AST_PARITY_KEPT: assert property ( // RQ3
        calcNow && modeEff == sdd_pkg::boundary_parity_preserving
        && !fieldMode && hField != 13'h0000
        |=> rowRes_q[0] == $past(reqRow[0])
    ) else $error("Mode 3 frame row lost its parity.");
    AST_MODE_GATED: assert property ( // RQ5
        sType != sdd_pkg::two_dim_surface_type || !media
        |-> modeEff == sdd_pkg::boundary_normal
    ) else $error("Boundary mode acted outside 2D media reads.");
    AST_RESERVED_MODE: assert property ( // RQ24
        modeRaw == sdd_pkg::boundary_reserved
        |-> modeEff == sdd_pkg::boundary_normal
    ) else $error("Reserved boundary mode not treated as mode 0.");
    AST_FACE_BORDER: assert property ( // RQ6
        calcNow && sType == sdd_pkg::cube_surface_type
        |=> faceBorderOut == !faceFetchOut
    ) else $error("Face fetch and border flags disagree.");
    AST_FACE_ORDER: assert property ( // RQ7
        calcNow && sType == sdd_pkg::cube_surface_type && faceIdx == 3'h0
        |=> faceFetchOut == $past(faceMask[`SDD_FACE_HI])
    ) else $error("Face zero is not mapped to the top mask bit.");
    AST_FACE_IGNORED: assert property ( // RQ9
        calcNow && sType != sdd_pkg::cube_surface_type
        |=> faceFetchOut && !faceBorderOut
    ) else $error("Face mask used on a non-cube surface.");
    AST_BASE_READ: assert property ( // RQ10
        ce && readTake && avs_address == `SDD_OFF_DESC1
        |=> avs_readdata == $past(desc1_q) && !avs_waitrequest
    ) else $error("Base address readback mismatch.");
    AST_BASE_UNTILED: assert property ( // RQ12
        calcNow |=> (addr_q - $past(desc1_q)) >> 10
        == {10'h000, $past(offset_q[31:10])}
    ) else $error("Tiling altered the base address.");
    AST_HEIGHT: assert property ( // RQ15
        calcNow |=> size_q[27:14] == {1'b0, $past(hField)} + 14'h0001
    ) else $error("Height count is not field plus one.");
    AST_WIDTH: assert property ( // RQ16
        calcNow |=> size_q[13:0] == {1'b0, $past(wField)} + 14'h0001
    ) else $error("Width count is not field plus one.");
    AST_BUF_LOW: assert property ( // RQ17
        calcNow |=> bufCnt_q[19:0] == {$past(hField), $past(wField[6:0])}
    ) else $error("Buffer count low slices misplaced.");
    AST_FIELD_HEIGHT: assert property ( // RQ19
        calcNow |=> size_q[28] == $past(fieldMode)
    ) else $error("Field height flag wrong.");
    AST_DWORD_WIDTH: assert property ( // RQ20
        calcNow |=> size_q[29] == $past(media)
    ) else $error("Doubleword width flag wrong.");
    AST_BUF_HIGH: assert property ( // RQ23
        calcNow |=> bufCnt_q[26:20] == $past(dField[6:0])
    ) else $error("Buffer count top slice misplaced.");
    AST_ONE_ACK: assert property (
        ce && !avs_waitrequest |=> avs_waitrequest
    ) else $error("Acknowledge lasted more than one cycle.");

    COV_PARITY: cover property (
        calcNow && modeEff == sdd_pkg::boundary_parity_preserving);
    COV_FIELD_FRAME: cover property (calcNow && fieldMode
        && modeEff == sdd_pkg::boundary_nearest_frame_row);
    COV_BORDER: cover property (calcNow && !faceFetch);
    COV_WRITE: cover property (ce && writeHit);

endmodule
